// >>> hdl/sense_channel_config_defs.svh
// Register offsets, field positions, reset values and scale factors
`ifndef SENSE_CHANNEL_CONFIG_DEFS_SVH
`define SENSE_CHANNEL_CONFIG_DEFS_SVH
`define OFF_BUTTON_BLOCK_AND_LEVELS 16'hA004
`define OFF_BUTTON_BETA_FILTERS 16'hA005
`define OFF_BUTTON_FAST_FILTERS 16'hA006
`define OFF_CHANNEL_GENERAL_SETTINGS 16'hB000
`define OFF_TUNING_BASE_TARGET 16'hB001
`define OFF_TUNING_FRACTION_MIRRORS 16'hB002
`define OFF_TUNING_COMPENSATION 16'hB003
`define OFF_ENCODER_SEGMENT_COUNT 16'hC000
`define OFF_COIL_A_CHANNEL_REFERENCE 16'hC001
`define OFF_COIL_A_ENTER_THRESHOLD 16'hC002
`define OFF_COIL_A_EXIT_THRESHOLD 16'hC003
`define OFF_COIL_B_CHANNEL_REFERENCE 16'hC004
`define OFF_COIL_B_ENTER_THRESHOLD 16'hC005
`define OFF_COIL_B_EXIT_THRESHOLD 16'hC006
`define CHANNEL_STRIDE 16'h0100
`define CHANNEL_STRIDE_SHIFT 8
`define NUM_CHANNELS 6
`define BLOCK_NONE 8'hFF
`define BLOCK_SEL_LSB 8
`define LEVELS_LSB 2
`define TEMP_COMP_BIT 1
`define LINEARISE_BIT 0
`define TUNE_BAND_LSB 12
`define GLOBAL_HALT_BIT 11
`define INVERT_BIT 10
`define TWO_WAY_BIT 9
`define CH_ENABLE_BIT 8
`define BIAS_SEL_LSB 0
`define TARGET_LSB 8
`define BASE_LSB 3
`define TUNE_MODE_LSB 0
`define FINE_DIV_LSB 9
`define COARSE_MUL_LSB 5
`define COARSE_DIV_LSB 0
`define COMP_DIV_LSB 11
`define COMP_SEL_LSB 0
`define TARGET_SHIFT 3
`define BASE_SHIFT 4
`define FIXED_REF_SHIFT 3
`define MAX_CHANNEL 8'h05
`define RESET_WORD 16'h0000
`define RESET_BLOCK_WORD 16'hFF00
`endif

// >>> hdl/sense_channel_config_pkg.sv
// Types shared by the sensing configuration block
package sense_channel_config_pkg;
   typedef enum logic [2:0] {
      tune_off, tune_comp_only, tune_from_comp_div, tune_from_fine_div,
      tune_from_coarse_div, tune_full
   } tune_mode_t;
   typedef enum {bus_idle, bus_write, bus_read} bus_state_t;
   typedef logic [15:0] word_t;
endpackage

// >>> hdl/coil_detector.sv
// One encoder coil: reference choice and enter/exit hysteresis
`timescale 1ns/100ps
`default_nettype none
module coil_detector
   import sense_channel_config_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [15:0] chan_ref_word,
   input wire logic signed [15:0] enter_thr,
   input wire logic signed [15:0] exit_thr,
   input wire logic [6*16-1:0] counts_all,
   output logic active
);
`include "sense_channel_config_defs.svh"
   typedef struct packed {
      logic active;
   } coil_state_t;
   coil_state_t st_q, st_d;
   logic [7:0] ch_sel, ref_sel;
   logic [15:0] meas, refv;
   logic signed [16:0] delta;
   always_comb begin
      ch_sel = chan_ref_word[7:0];
      ref_sel = chan_ref_word[15:8];
      meas = (ch_sel <= `MAX_CHANNEL) ? counts_all[ch_sel[2:0]*16 +: 16] : 16'h0000;
      if (ref_sel <= `MAX_CHANNEL) begin
         refv = counts_all[ref_sel[2:0]*16 +: 16];
      end else begin
         refv = {5'h00, ref_sel, 3'h0};
      end
      delta = $signed({1'b0, meas}) - $signed({1'b0, refv});
      st_d = st_q;
      // Hysteresis keeps the flag steady while the delta sits between the two thresholds
      if (!st_q.active && delta >= $signed({enter_thr[15], enter_thr})) begin
         st_d.active = 1'b1;
      end else if (st_q.active && delta < $signed({exit_thr[15], exit_thr})) begin
         st_d.active = 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign active = st_q.active;
endmodule
`default_nettype wire

// >>> hdl/channel_processor.sv
// One channel: count correction, direction test and level enables
`timescale 1ns/100ps
`default_nettype none
module channel_processor
   import sense_channel_config_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [15:0] block_word,
   input wire logic [15:0] general_word,
   input wire logic [15:0] base_target_word,
   input wire logic [15:0] raw_counts,
   input wire logic [15:0] long_term_average,
   input wire logic sample_valid,
   input wire logic blocked,
   output logic [15:0] counts_out,
   output logic [2:0] level_enable,
   output logic below_avg,
   output logic above_avg
);
`include "sense_channel_config_defs.svh"
   typedef struct packed {
      logic [15:0] counts;
      logic below;
      logic above;
   } chan_state_t;
   chan_state_t st_q, st_d;
   logic [10:0] target;
   logic [26:0] comp_prod;
   logic [15:0] comp_counts;
   logic [21:0] target_sq;
   logic [21:0] lin_q;
   logic [1:0] levels;
   always_comb begin
      target = {base_target_word[`TARGET_LSB +: 8], 3'h0};
      comp_prod = 27'(target) * 27'(raw_counts);
      comp_counts = raw_counts;
      if (block_word[`TEMP_COMP_BIT] && long_term_average != 16'h0000) begin
         comp_counts = 16'(comp_prod / 27'(long_term_average));
      end
      target_sq = 22'(target) * 22'(target);
      lin_q = (comp_counts == 16'h0000) ? 22'h3FFFFF : target_sq / 22'(comp_counts);
      levels = block_word[`LEVELS_LSB +: 2];
      case (levels)
         2'h0: level_enable = 3'h0;
         2'h1: level_enable = 3'h1;
         2'h2: level_enable = 3'h3;
         default: level_enable = 3'h7;
      endcase
      if (!general_word[`CH_ENABLE_BIT] || blocked) begin
         level_enable = 3'h0;
      end
      st_d = st_q;
      if (sample_valid && general_word[`CH_ENABLE_BIT]) begin
         st_d.counts = block_word[`LINEARISE_BIT] ?
            ((lin_q > 22'h00FFFF) ? 16'hFFFF : lin_q[15:0]) : comp_counts;
         if (general_word[`TWO_WAY_BIT]) begin
            st_d.below = st_d.counts < long_term_average;
            st_d.above = st_d.counts > long_term_average;
         end else begin
            st_d.below = !general_word[`INVERT_BIT] && st_d.counts < long_term_average;
            st_d.above = general_word[`INVERT_BIT] && st_d.counts > long_term_average;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign counts_out = st_q.counts;
   assign below_avg = st_q.below;
   assign above_avg = st_q.above;
endmodule
`default_nettype wire

// >>> hdl/sense_channel_config.sv
// Per-channel sensing configuration registers, encoder setup and gray state
`timescale 1ns/100ps
`default_nettype none
module sense_channel_config
   import sense_channel_config_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic low_power,
   input wire logic sample_valid,
   input wire logic [6*16-1:0] raw_counts_all,
   input wire logic [6*16-1:0] long_term_average_all,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   output logic reg_err,
   output logic [6*16-1:0] counts_out_all,
   output logic [6*3-1:0] level_enable_all,
   output logic [5:0] below_avg,
   output logic [5:0] above_avg,
   output logic [5:0] channel_active,
   output logic [5:0] global_halt_en,
   output logic [6*2-1:0] bias_select_all,
   output logic [6*3-1:0] tune_mode_all,
   output logic [6*16-1:0] tune_band_all,
   output logic [6*16-1:0] tune_base_all,
   output logic [6*8-1:0] beta_active_all,
   output logic [6*8-1:0] fast_beta_all,
   output logic [1:0] gray_state,
   output logic [15:0] encoder_segments
);
`include "sense_channel_config_defs.svh"
   localparam int NCH = `NUM_CHANNELS;
   typedef struct packed {
      logic [NCH-1:0][15:0] block_w;
      logic [NCH-1:0][15:0] beta_w;
      logic [NCH-1:0][15:0] fast_w;
      logic [NCH-1:0][15:0] gen_w;
      logic [NCH-1:0][15:0] bt_w;
      logic [NCH-1:0][15:0] frac_w;
      logic [NCH-1:0][15:0] comp_w;
      logic [15:0] seg_w;
      logic [1:0][15:0] coil_sel_w;
      logic [1:0][15:0] enter_w;
      logic [1:0][15:0] exit_w;
      logic [15:0] rdata;
      logic rvalid;
      logic err;
      logic [NCH-1:0][2:0] lvl_en;
      logic [NCH-1:0] halt;
      logic [NCH-1:0][1:0] bias;
      logic [NCH-1:0][2:0] tmode;
      logic [NCH-1:0][15:0] band;
      logic [NCH-1:0][15:0] base;
      logic [NCH-1:0][7:0] beta_act;
      logic [NCH-1:0][7:0] fast_act;
      logic [NCH-1:0] ch_act;
      logic [1:0] gray;
   } top_state_t;
   top_state_t st_q, st_d;
   logic [6*16-1:0] ch_counts;
   logic [6*3-1:0] ch_lvl;
   logic [5:0] ch_below, ch_above;
   logic [NCH-1:0] ch_blocked;
   logic [1:0] coil_active;
   logic [7:0] idx;
   logic [15:0] local_off;
   logic idx_ok, hit;
   logic [15:0] rd;
   logic [10:0] tgt;

   // Blocking: a channel is blocked while the channel it names is detecting
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         ch_blocked[c] = 1'b0;
         for (int b = 0; b < NCH; b++) begin
            if (st_q.block_w[c][`BLOCK_SEL_LSB +: 8] == 8'(b) && b != c) begin
               ch_blocked[c] = ch_blocked[c] | ch_below[b] | ch_above[b];
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         channel_processor u_ch (
            .mclk(mclk),
            .nrst(nrst),
            .block_word(st_q.block_w[g]),
            .general_word(st_q.gen_w[g]),
            .base_target_word(st_q.bt_w[g]),
            .raw_counts(raw_counts_all[g*16 +: 16]),
            .long_term_average(long_term_average_all[g*16 +: 16]),
            .sample_valid(sample_valid),
            .blocked(ch_blocked[g]),
            .counts_out(ch_counts[g*16 +: 16]),
            .level_enable(ch_lvl[g*3 +: 3]),
            .below_avg(ch_below[g]),
            .above_avg(ch_above[g])
         );
      end
      for (g = 0; g < 2; g++) begin : g_coil
         coil_detector u_coil (
            .mclk(mclk),
            .nrst(nrst),
            .chan_ref_word(st_q.coil_sel_w[g]),
            .enter_thr(st_q.enter_w[g]),
            .exit_thr(st_q.exit_w[g]),
            .counts_all(ch_counts),
            .active(coil_active[g])
         );
      end
   endgenerate

   always_comb begin
      st_d = st_q;
      st_d.rvalid = 1'b0;
      st_d.err = 1'b0;
      idx = {4'h0, reg_addr[11:8]};
      local_off = {reg_addr[15:12], 4'h0, reg_addr[7:0]};
      idx_ok = idx < 8'(NCH);
      hit = 1'b1;
      rd = 16'h0000;
      case (local_off)
         `OFF_BUTTON_BLOCK_AND_LEVELS & 16'hF0FF: rd = st_q.block_w[idx[2:0]];
         `OFF_BUTTON_BETA_FILTERS & 16'hF0FF: rd = st_q.beta_w[idx[2:0]];
         `OFF_BUTTON_FAST_FILTERS & 16'hF0FF: rd = st_q.fast_w[idx[2:0]];
         `OFF_CHANNEL_GENERAL_SETTINGS: rd = st_q.gen_w[idx[2:0]];
         `OFF_TUNING_BASE_TARGET: rd = st_q.bt_w[idx[2:0]];
         `OFF_TUNING_FRACTION_MIRRORS: rd = st_q.frac_w[idx[2:0]];
         `OFF_TUNING_COMPENSATION: rd = st_q.comp_w[idx[2:0]];
         default: hit = 1'b0;
      endcase
      hit = hit && idx_ok;
      // Encoder words exist once, with no per-channel copies
      case (reg_addr)
         `OFF_ENCODER_SEGMENT_COUNT: begin hit = 1'b1; rd = st_q.seg_w; end
         `OFF_COIL_A_CHANNEL_REFERENCE: begin hit = 1'b1; rd = st_q.coil_sel_w[0]; end
         `OFF_COIL_A_ENTER_THRESHOLD: begin hit = 1'b1; rd = st_q.enter_w[0]; end
         `OFF_COIL_A_EXIT_THRESHOLD: begin hit = 1'b1; rd = st_q.exit_w[0]; end
         `OFF_COIL_B_CHANNEL_REFERENCE: begin hit = 1'b1; rd = st_q.coil_sel_w[1]; end
         `OFF_COIL_B_ENTER_THRESHOLD: begin hit = 1'b1; rd = st_q.enter_w[1]; end
         `OFF_COIL_B_EXIT_THRESHOLD: begin hit = 1'b1; rd = st_q.exit_w[1]; end
         default: ;
      endcase
      if (reg_wr && hit) begin
         case (reg_addr)
            `OFF_ENCODER_SEGMENT_COUNT: st_d.seg_w = reg_wdata;
            `OFF_COIL_A_CHANNEL_REFERENCE: st_d.coil_sel_w[0] = reg_wdata;
            `OFF_COIL_A_ENTER_THRESHOLD: st_d.enter_w[0] = reg_wdata;
            `OFF_COIL_A_EXIT_THRESHOLD: st_d.exit_w[0] = reg_wdata;
            `OFF_COIL_B_CHANNEL_REFERENCE: st_d.coil_sel_w[1] = reg_wdata;
            `OFF_COIL_B_ENTER_THRESHOLD: st_d.enter_w[1] = reg_wdata;
            `OFF_COIL_B_EXIT_THRESHOLD: st_d.exit_w[1] = reg_wdata;
            default: begin
               case (local_off)
                  `OFF_BUTTON_BLOCK_AND_LEVELS & 16'hF0FF:
                     st_d.block_w[idx[2:0]] = reg_wdata & 16'hFF0F;
                  `OFF_BUTTON_BETA_FILTERS & 16'hF0FF:
                     st_d.beta_w[idx[2:0]] = reg_wdata;
                  `OFF_BUTTON_FAST_FILTERS & 16'hF0FF:
                     st_d.fast_w[idx[2:0]] = reg_wdata;
                  `OFF_CHANNEL_GENERAL_SETTINGS:
                     st_d.gen_w[idx[2:0]] = reg_wdata & 16'h3FFF;
                  `OFF_TUNING_BASE_TARGET:
                     st_d.bt_w[idx[2:0]] = reg_wdata;
                  `OFF_TUNING_FRACTION_MIRRORS:
                     st_d.frac_w[idx[2:0]] = reg_wdata & 16'h3FFF;
                  `OFF_TUNING_COMPENSATION:
                     st_d.comp_w[idx[2:0]] = reg_wdata & 16'hFBFF;
                  default: ;
               endcase
            end
         endcase
      end
      if (reg_rd) begin
         st_d.rvalid = 1'b1;
         st_d.rdata = hit ? rd : 16'h0000;
      end
      // Unmapped accesses read zero and raise an error pulse instead of hanging the host
      st_d.err = (reg_rd || reg_wr) && !hit;
      for (int c = 0; c < NCH; c++) begin
         tgt = {st_q.bt_w[c][`TARGET_LSB +: 8], 3'h0};
         st_d.lvl_en[c] = ch_lvl[c*3 +: 3];
         st_d.halt[c] = st_q.gen_w[c][`GLOBAL_HALT_BIT];
         st_d.bias[c] = st_q.gen_w[c][`BIAS_SEL_LSB +: 2];
         st_d.ch_act[c] = st_q.gen_w[c][`CH_ENABLE_BIT];
         st_d.tmode[c] = st_q.bt_w[c][`TUNE_MODE_LSB +: 3];
         st_d.base[c] = {7'h00, st_q.bt_w[c][`BASE_LSB +: 5], 4'h0};
         st_d.band[c] = {5'h00, tgt >> (4 - {1'b0, st_q.gen_w[c][`TUNE_BAND_LSB +: 2]})};
         st_d.beta_act[c] = low_power ?
            {st_q.beta_w[c][15:12], st_q.beta_w[c][7:4]} :
            {st_q.beta_w[c][11:8], st_q.beta_w[c][3:0]};
         st_d.fast_act[c] = {st_q.fast_w[c][15:8] == 8'h00 ? 4'h0 : 4'hF,
            low_power ? st_q.fast_w[c][7:4] : st_q.fast_w[c][3:0]};
      end
      // Bit 0 follows coil A and bit 1 coil B, which walks 00, 01, 11, 10
      st_d.gray = {coil_active[1], coil_active[0]};
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_q <= '0;
         for (int c = 0; c < NCH; c++) begin
            st_q.block_w[c] <= `RESET_BLOCK_WORD;
         end
      end else begin
         st_q <= st_d;
      end
   end

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         level_enable_all[c*3 +: 3] = st_q.lvl_en[c];
         bias_select_all[c*2 +: 2] = st_q.bias[c];
         tune_mode_all[c*3 +: 3] = st_q.tmode[c];
         tune_band_all[c*16 +: 16] = st_q.band[c];
         tune_base_all[c*16 +: 16] = st_q.base[c];
         beta_active_all[c*8 +: 8] = st_q.beta_act[c];
         fast_beta_all[c*8 +: 8] = st_q.fast_act[c];
      end
   end
   assign reg_rdata = st_q.rdata;
   assign reg_rvalid = st_q.rvalid;
   assign reg_err = st_q.err;
   assign counts_out_all = ch_counts;
   assign below_avg = ch_below;
   assign above_avg = ch_above;
   assign channel_active = st_q.ch_act;
   assign global_halt_en = st_q.halt;
   assign gray_state = st_q.gray;
   assign encoder_segments = st_q.seg_w;
endmodule
`default_nettype wire

// >>> verif/sense_channel_config_properties.sv
// Concurrent checks on the ports of the sensing configuration block
`timescale 1ns/100ps
`default_nettype none
module sense_channel_config_properties
   import sense_channel_config_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic low_power,
   input wire logic sample_valid,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic reg_err,
   input wire logic [6*16-1:0] counts_out_all,
   input wire logic [6*3-1:0] level_enable_all,
   input wire logic [5:0] channel_active,
   input wire logic [5:0] global_halt_en,
   input wire logic [6*2-1:0] bias_select_all,
   input wire logic [6*3-1:0] tune_mode_all,
   input wire logic [6*16-1:0] tune_base_all,
   input wire logic [6*8-1:0] beta_active_all
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_wr(a);
      reg_wr && reg_addr == a;
   endsequence
   property p_gen;
      word_t d;
      (s_wr(16'hB000), d = reg_wdata) |-> ##2 bias_select_all[1:0] == d[1:0]
         && global_halt_en[0] == d[11] && channel_active[0] == d[8];
   endproperty
   property p_base;
      word_t d;
      (s_wr(16'hB001), d = reg_wdata) |-> ##2 tune_base_all[15:0] == {7'h00, d[7:3], 4'h0}
         && tune_mode_all[2:0] == d[2:0];
   endproperty
   property p_beta;
      word_t d;
      // Only valid while the power mode stays put around the write
      (s_wr(16'hA005), d = reg_wdata) |-> ##2 beta_active_all[7:0] ==
         (low_power ? {d[15:12], d[7:4]} : {d[11:8], d[3:0]});
   endproperty
   a_read_answer: assert property (reg_rd |=> reg_rvalid || reg_err)
      else $error("read got no answer");
   a_valid_cause: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("read data without a read");
   a_err_cause: assert property (reg_err |-> $past(reg_rd || reg_wr))
      else $error("error flag without a request");
   a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_level_cumul: assert property ((!level_enable_all[1] || level_enable_all[0])
      && (!level_enable_all[2] || level_enable_all[1]))
      else $error("level enables not cumulative");
   a_gen_fields: assert property (p_gen)
      else $error("general settings not applied");
   a_base_scale: assert property (p_base)
      else $error("tuning base or mode wrong");
   a_beta_pair: assert property (p_beta)
      else $error("beta pair wrong for power mode");
   a_counts_quiet: assert property (!$past(sample_valid) |-> $stable(counts_out_all))
      else $error("counts moved without a sample");
endmodule
bind sense_channel_config sense_channel_config_properties u_props (
   .mclk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .low_power, .sample_valid,
   .reg_rdata, .reg_rvalid, .reg_err, .counts_out_all, .level_enable_all, .channel_active,
   .global_halt_en, .bias_select_all, .tune_mode_all, .tune_base_all, .beta_active_all
);
`default_nettype wire

// >>> verif/host_bus_model.sv
// Host side model: turns bench requests into single-cycle register pulses
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
   input wire logic mclk,
   input wire logic go,
   input wire logic go_wr,
   input wire logic [15:0] go_addr,
   input wire logic [15:0] go_wdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_addr,
   output logic [15:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
   end
   always @(posedge mclk) begin
      reg_wr <= go && go_wr;
      reg_rd <= go && !go_wr;
      // Address and data are not held after the pulse, so late sampling sees junk
      reg_addr <= go ? go_addr : ~reg_addr;
      reg_wdata <= go ? go_wdata : ~reg_wdata;
   end
endmodule
`default_nettype wire

// >>> verif/sense_channel_config_test.sv
// Self-checking bench for the sensing configuration block
`timescale 1ns/100ps
`default_nettype none
module sense_channel_config_test
   import sense_channel_config_pkg::*;
;
   typedef struct packed {logic [15:0] d; logic e; logic r;} note_t;
   logic mclk, nrst, go, go_wr, low_power, sample_valid, reg_wr, reg_rd, reg_rvalid, reg_err;
   logic [15:0] go_addr, go_wdata, reg_addr, reg_wdata, reg_rdata, encoder_segments;
   logic [6*16-1:0] raw_counts_all, long_term_average_all, counts_out_all;
   logic [6*16-1:0] tune_band_all, tune_base_all;
   logic [6*3-1:0] level_enable_all, tune_mode_all;
   logic [5:0] below_avg, above_avg, channel_active, global_halt_en;
   logic [6*2-1:0] bias_select_all;
   logic [6*8-1:0] beta_active_all, fast_beta_all;
   logic [1:0] gray_state;
   logic [31:0] lfsr_q;
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   note_t exp_q[$];
   note_t n;
   word_t ofs[14] = '{16'hA004, 16'hA005, 16'hA006, 16'hB000, 16'hB001, 16'hB002, 16'hB003,
      16'hC000, 16'hC001, 16'hC002, 16'hC003, 16'hC004, 16'hC005, 16'hC006};
   word_t msk[14] = '{16'hFF0F, 16'hFFFF, 16'hFFFF, 16'h3FFF, 16'hFFFF, 16'h3FFF, 16'hFBFF,
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
   sense_channel_config u_dut (
      .mclk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .low_power, .sample_valid,
      .raw_counts_all, .long_term_average_all, .reg_rdata, .reg_rvalid, .reg_err,
      .counts_out_all, .level_enable_all, .below_avg, .above_avg, .channel_active,
      .global_halt_en, .bias_select_all, .tune_mode_all, .tune_band_all, .tune_base_all,
      .beta_active_all, .fast_beta_all, .gray_state, .encoder_segments
   );
   host_bus_model u_host (
      .mclk, .go, .go_wr, .go_addr, .go_wdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata
   );
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      cmp_count++;
      if (seen !== want) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk);
      go <= 1'b1;
      go_wr <= wr;
      go_addr <= a;
      go_wdata <= d;
      @(posedge mclk);
      go <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] d, input logic e);
      exp_q.push_back('{d, e, 1'b1});
      acc(1'b0, a, 16'h0000);
   endtask
   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic cfg(input logic [15:0] a, input logic [15:0] g);
      wr(16'hA004, a);
      wr(16'hB000, g);
   endtask
   task automatic samp(input logic [15:0] r0, input logic [15:0] r1, input logic [15:0] l0);
      @(posedge mclk);
      raw_counts_all[31:0] <= {r1, r0};
      long_term_average_all[15:0] <= l0;
      sample_valid <= 1'b1;
      @(posedge mclk);
      sample_valid <= 1'b0;
      repeat (4) @(posedge mclk);
      #1;
   endtask
   task automatic cnt(input logic [15:0] c, input logic b, input logic a);
      check(counts_out_all[15:0], c);
      check({15'h0000, below_avg[0]}, {15'h0000, b});
      check({15'h0000, above_avg[0]}, {15'h0000, a});
   endtask
   task automatic coil(input logic [15:0] r0, input logic [15:0] r1, input logic [1:0] g);
      samp(r0, r1, 16'd100);
      check({14'h0000, gray_state}, {14'h0000, g});
   endtask
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         end_sim();
      end
   end
   // One note is taken per answer, whether data or an error flag
   always @(negedge mclk) begin
      if (nrst === 1'b1 && (reg_rvalid !== 1'b0 || reg_err !== 1'b0)) begin
         if (exp_q.size() == 0) begin
            err_count++;
            $display("[ERR] %0t answer without a request", $time);
         end else begin
            n = exp_q.pop_front();
            if (n.r) check(reg_rdata, n.d);
            check({15'h0000, reg_err}, {15'h0000, n.e});
         end
      end
   end
   initial begin
      nrst = 1'b0;
      go = 1'b0;
      go_wr = 1'b0;
      go_addr = 16'h0000;
      go_wdata = 16'h0000;
      low_power = 1'b0;
      sample_valid = 1'b0;
      raw_counts_all = '0;
      long_term_average_all = {6{16'd1000}};
      lfsr_q = 32'h013E1410;
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      for (int c = 0; c < 6; c++) begin
         rd(16'hA004 + 16'(c << 8), 16'hFF00, 1'b0);
         rd(16'hB000 + 16'(c << 8), 16'h0000, 1'b0);
      end
      for (int i = 0; i < 14; i++) begin
         for (int c = 0; c < ((i < 7) ? 6 : 1); c++) begin
            lfsr_q = lfsr_next(lfsr_q);
            wr(ofs[i] + 16'(c << 8), lfsr_q[15:0]);
            rd(ofs[i] + 16'(c << 8), lfsr_q[15:0] & msk[i], 1'b0);
         end
      end
      rd(16'hA007, 16'h0000, 1'b1);
      rd(16'hB600, 16'h0000, 1'b1);
      rd(16'hD000, 16'h0000, 1'b1);
      exp_q.push_back('{16'h0000, 1'b1, 1'b0});
      wr(16'hC007, 16'h1234);
      for (int k = 0; k < 6; k++) begin
         wr(16'hB001 + 16'(k << 8), {8'h20, 5'(k + 3), 3'(k)});
         wr(16'hB000 + 16'(k << 8), {2'b00, 2'(k), 4'b1000, 6'h00, 2'(k)});
      end
      wr(16'hA005, 16'h4321);
      wr(16'hC000, 16'h0024);
      wr(16'hA006, 16'h0A65);
      wr(16'hA106, 16'h0021);
      settle();
      for (int k = 0; k < 6; k++) begin
         check(tune_band_all[k*16+:16], 16'h0100 >> (4 - k % 4));
         check(tune_base_all[k*16+:16], 16'((k + 3) * 16));
         check(16'(tune_mode_all[k*3+:3]), 16'(k));
         check(16'(bias_select_all[k*2+:2]), 16'(k % 4));
         check(16'(global_halt_en[k]), 16'h0001);
      end
      check(16'(beta_active_all[7:0]), 16'h0031);
      check(16'(fast_beta_all[7:0]), 16'h00F5);
      check(16'(fast_beta_all[15:8]), 16'h0001);
      check(encoder_segments, 16'h0024);
      @(posedge mclk);
      low_power <= 1'b1;
      settle();
      check(16'(beta_active_all[7:0]), 16'h0042);
      check(16'(fast_beta_all[7:0]), 16'h00F6);
      wr(16'hB001, 16'h1000);
      cfg(16'hFF0C, 16'h0100);
      samp(16'd80, 16'd0, 16'd100);
      cnt(16'd80, 1'b1, 1'b0);
      cfg(16'hFF0E, 16'h0100);
      samp(16'd200, 16'd0, 16'd100);
      cnt(16'd256, 1'b0, 1'b0);
      cfg(16'hFF0D, 16'h0100);
      samp(16'd64, 16'd0, 16'd100);
      cnt(16'd256, 1'b0, 1'b0);
      cfg(16'hFF0F, 16'h0100);
      samp(16'd200, 16'd0, 16'd100);
      cnt(16'd64, 1'b1, 1'b0);
      cfg(16'hFF0C, 16'h0500);
      samp(16'd150, 16'd0, 16'd100);
      cnt(16'd150, 1'b0, 1'b1);
      samp(16'd50, 16'd0, 16'd100);
      cnt(16'd50, 1'b0, 1'b0);
      cfg(16'hFF0C, 16'h0700);
      samp(16'd50, 16'd0, 16'd100);
      cnt(16'd50, 1'b1, 1'b0);
      samp(16'd150, 16'd0, 16'd100);
      cnt(16'd150, 1'b0, 1'b1);
      for (int k = 0; k < 4; k++) begin
         cfg(16'hFF00 | 16'(k << 2), 16'h0100);
         samp(16'd50, 16'd0, 16'd100);
         check(16'(level_enable_all[2:0]), 16'((1 << k) - 1));
      end
      wr(16'hA104, 16'h000C);
      wr(16'hB100, 16'h0100);
      samp(16'd50, 16'd500, 16'd100);
      check(16'(level_enable_all[5:3]), 16'h0000);
      samp(16'd150, 16'd500, 16'd100);
      check(16'(level_enable_all[5:3]), 16'h0007);
      cfg(16'hFF0C, 16'h0000);
      samp(16'd77, 16'd500, 16'd100);
      cnt(16'd150, 1'b0, 1'b0);
      cfg(16'hFF0C, 16'h0100);
      wr(16'hC001, 16'h1000);
      wr(16'hC004, 16'h1001);
      wr(16'hC002, 16'd50);
      wr(16'hC005, 16'd50);
      wr(16'hC003, 16'd20);
      wr(16'hC006, 16'd20);
      coil(16'd200, 16'd128, 2'b01);
      coil(16'd200, 16'd200, 2'b11);
      coil(16'd160, 16'd200, 2'b11);
      coil(16'd140, 16'd200, 2'b10);
      coil(16'd140, 16'd100, 2'b00);
      wr(16'hC001, 16'h0100);
      coil(16'd300, 16'd200, 2'b11);
      coil(16'd210, 16'd200, 2'b10);
      repeat (4) @(posedge mclk);
      check(16'(exp_q.size()), 16'h0000);
      end_sim();
   end
endmodule
`default_nettype wire
